// >>> umg_feature_regs.sv
/*
 * Feature, modem status and general-purpose pin registers of a single
 * serial port, plus half-duplex direction control.
 * Assumes the host decoder, transmitter, receiver, FIFOs and baud generator
 * sit outside on the same clock and supply the strobes and levels below.
 */
`timescale 1ns/100ps
module umg_feature_regs (
  // Clock, reset, clock enable
  input  wire  logic                     CLK,
  input  wire  logic                     RST_N,
  input  wire  logic                     CE,
  // Host register port
  input  wire  logic [umg_pkg::ADDR_W-1:0] ADDR,
  input  wire  logic                     WR,
  input  wire  logic                     RD,
  input  wire  logic [7:0]               WR_DATA,
  output logic       [7:0]               RD_DATA,
  output logic                           RD_HIT,
  // Neighbouring register values
  input  wire  logic [7:0]               LINE_CTRL,
  input  wire  logic [7:0]               MODEM_CTRL,
  input  wire  logic [7:0]               INT_ENABLE,
  input  wire  logic [7:0]               ENH_FEATURE,
  input  wire  logic [7:0]               FEATURE_CTRL,
  input  wire  logic                     FIFO_EN,
  // Transmitter and receiver status
  input  wire  logic [7:0]               RX_LEVEL,
  input  wire  logic [7:0]               TX_LEVEL,
  input  wire  logic                     THR_WR,
  input  wire  logic                     TX_EMPTY,
  input  wire  logic                     TX_SENT,
  input  wire  logic                     BIT_TICK,
  input  wire  logic                     RX_ERR_ENQ,
  input  wire  logic                     RX_ERR_AT_HEAD,
  input  wire  logic                     LSR_RD,
  // Modem and pin inputs
  input  wire  logic                     CTS_N,
  input  wire  logic                     DSR_N,
  input  wire  logic                     RI_N,
  input  wire  logic                     CD_N,
  input  wire  logic [umg_pkg::GPIO_N-1:0] GPIO_IN,
  // Pin outputs
  output logic [umg_pkg::GPIO_N-1:0]     GPIO_OUT,
  output logic [umg_pkg::GPIO_N-1:0]     GPIO_OE_N,
  output logic                           RTS_N,
  output logic                           MODEM_OE_N,
  // Controls to transmitter and receiver
  output logic                           TX_PERMIT,
  output logic                           RX_ENABLE,
  output logic                           TX_BYPASS,
  output logic                           TX_NINTH,
  output logic                           NINE_BIT_MODE,
  output logic                           IR_FAST,
  output logic       [2:0]               IR_PULSE_16THS,
  // Interrupt requests
  output logic                           MODEM_IRQ,
  output logic                           GPIO_IRQ,
  output logic                           LINE_IRQ
);
  import umg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode.
  logic       wr_en;
  logic       rd_en;
  logic       gpio_map;
  logic       swap;
  logic       rs485;
  logic       loop;
  logic       wr_spr;
  logic       wr_enhanced_mode_ctrl;
  logic       wr_scr;
  logic       rd_msr;
  logic       rd_count;
  logic [7:0] sfr_reg;
  logic [7:0] enhanced_mode_ctrl_reg;
  logic [7:0] shr_reg;
  logic [7:0] scratch_reg;
  logic       alt_reg;

  assign wr_en    = WR & CE;
  assign rd_en    = RD & CE;
  assign gpio_map = sfr_reg[SF_GPIO_EN];
  assign swap     = FEATURE_CTRL[FC_SWAP];
  assign rs485    = FEATURE_CTRL[FC_RS485];
  assign loop     = MODEM_CTRL[MC_LOOP];
  assign wr_spr   = wr_en & (ADDR == ADR_SPR);
  assign wr_enhanced_mode_ctrl  = wr_spr & ~gpio_map & swap;
  assign wr_scr   = wr_spr & ~gpio_map & ~swap;
  assign rd_msr   = rd_en & (ADDR == ADR_MSR);
  assign rd_count = rd_en & (ADDR == ADR_SPR) & ~gpio_map & swap;

  ////////////////////////////////////////////////////////////////////////
  // Modem inputs: synchronise, derive status, catch changes.
  logic [3:0] mdm_meta_reg;
  logic [3:0] mdm_sync_reg;
  logic [3:0] mdm_prev_reg;
  logic [3:0] delta_reg;
  logic [3:0] mdm_stat;
  logic [3:0] mdm_event;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mdm_meta_reg <= 4'hF;
      mdm_sync_reg <= 4'hF;
    end else if (CE) begin
      mdm_meta_reg <= {CD_N, RI_N, DSR_N, CTS_N};
      mdm_sync_reg <= mdm_meta_reg;
    end
  end

  // Order: CD, RI, DSR, CTS.
  assign mdm_stat = loop ?
    {MODEM_CTRL[MC_OP2], MODEM_CTRL[MC_OP1],
     MODEM_CTRL[MC_DTR], MODEM_CTRL[MC_RTS]} :
    ~mdm_sync_reg;
  // Ring reports only the end of ringing, when its status falls.
  assign mdm_event = {mdm_stat[3] ^ mdm_prev_reg[3],
                      mdm_prev_reg[2] & ~mdm_stat[2],
                      mdm_stat[1:0] ^ mdm_prev_reg[1:0]};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mdm_prev_reg <= 4'h0;
      delta_reg    <= 4'h0;
    end else if (CE) begin
      mdm_prev_reg <= mdm_stat;
      // A change seen in the reading cycle survives the clear.
      delta_reg <= (rd_msr ? 4'h0 : delta_reg) | mdm_event;
    end
  end

  assign MODEM_IRQ = INT_ENABLE[IE_MODEM] & (|delta_reg);

  ////////////////////////////////////////////////////////////////////////
  // Special function, setup and scratch registers.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sfr_reg  <= ZERO8;
      TX_NINTH <= 1'b0;
    end else if (CE) begin
      if (wr_en && ADDR == ADR_SFR) begin
        // Upper bits only change with enhanced features on.
        if (ENH_FEATURE[EF_ENH])
          sfr_reg <= WR_DATA;
        else
          sfr_reg <= (sfr_reg & ~SF_ALWAYS_MASK) |
                     (WR_DATA & SF_ALWAYS_MASK);
      end else if (THR_WR) begin
        sfr_reg[SF_ADDRBIT] <= 1'b0;
      end
      if (THR_WR)
        TX_NINTH <= sfr_reg[SF_ADDRBIT] &
                    (LINE_CTRL[5:3] == PAR_FORCE0);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shr_reg     <= ZERO8;
      scratch_reg <= SCRATCH_RST;
    end else if (CE) begin
      if (wr_en && ADDR == ADR_SHR)
        shr_reg <= WR_DATA;
      if (wr_scr)
        scratch_reg <= WR_DATA;
    end
  end

  assign NINE_BIT_MODE  = sfr_reg[SF_NINE];
  assign IR_FAST        = sfr_reg[SF_FASTIR];
  assign IR_PULSE_16THS = sfr_reg[SF_FASTIR] ?
                          IR_FAST_16THS : IR_SLOW_16THS;
  assign RX_ENABLE      = ~sfr_reg[SF_RXDIS];

  ////////////////////////////////////////////////////////////////////////
  // Enhanced mode register and level count selection.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      enhanced_mode_ctrl_reg <= ZERO8;
    end else if (CE) begin
      // A host write wins over the self-clear in the same cycle.
      if (wr_enhanced_mode_ctrl)
        enhanced_mode_ctrl_reg <= WR_DATA & EM_WR_MASK;
      else if (TX_SENT && TX_BYPASS)
        enhanced_mode_ctrl_reg[EM_IMM] <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N)
      alt_reg <= 1'b0;
    else if (CE) begin
      if (wr_enhanced_mode_ctrl)
        alt_reg <= 1'b0;
      else if (rd_count && enhanced_mode_ctrl_reg[1:0] == 2'b11)
        alt_reg <= ~alt_reg;
    end
  end

  assign TX_BYPASS  = enhanced_mode_ctrl_reg[EM_IMM] & FIFO_EN;
  assign MODEM_OE_N = enhanced_mode_ctrl_reg[EM_TRI];

  ////////////////////////////////////////////////////////////////////////
  // General-purpose pins, one slice per pin.
  logic [GPIO_N-1:0] gpio_meta_reg;
  logic [GPIO_N-1:0] gpio_sync_reg;
  logic [GPIO_N-1:0] lvl_reg;
  logic [GPIO_N-1:0] gint_reg;
  logic [GPIO_N-1:0] g3t_reg;
  logic [GPIO_N-1:0] ginv_reg;
  logic [GPIO_N-1:0] gsel_reg;
  logic [GPIO_N-1:0] gpio_rd;
  logic [GPIO_N-1:0] gpio_hit;

  genvar gi;
  generate
    for (gi = 0; gi < GPIO_N; gi++) begin : g_pin
      logic bank_hit;
      assign bank_hit = wr_en & gpio_map &
                        (sfr_reg[SF_BANK] == (gi >= 8));
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          gpio_meta_reg[gi] <= 1'b0;
          gpio_sync_reg[gi] <= 1'b0;
          lvl_reg[gi]  <= 1'b0;
          gint_reg[gi] <= 1'b0;
          g3t_reg[gi]  <= 1'b0;
          ginv_reg[gi] <= 1'b0;
          gsel_reg[gi] <= 1'b0;
        end else if (CE) begin
          gpio_meta_reg[gi] <= GPIO_IN[gi];
          gpio_sync_reg[gi] <= gpio_meta_reg[gi];
          if (bank_hit && ADDR == ADR_SPR && gsel_reg[gi])
            lvl_reg[gi] <= WR_DATA[gi % 8];
          if (bank_hit && ADDR == ADR_GINT)
            gint_reg[gi] <= WR_DATA[gi % 8];
          if (bank_hit && ADDR == ADR_G3T)
            g3t_reg[gi] <= WR_DATA[gi % 8];
          if (bank_hit && ADDR == ADR_GINV)
            ginv_reg[gi] <= WR_DATA[gi % 8];
          if (bank_hit && ADDR == ADR_GSEL)
            gsel_reg[gi] <= WR_DATA[gi % 8];
        end
      end
      assign gpio_rd[gi] = gsel_reg[gi] ? lvl_reg[gi]
                                        : gpio_sync_reg[gi];
      assign gpio_hit[gi] = ~gsel_reg[gi] & gint_reg[gi] &
                            (gpio_sync_reg[gi] ^ ginv_reg[gi]);
      assign GPIO_OUT[gi]  = lvl_reg[gi];
      assign GPIO_OE_N[gi] = ~(gsel_reg[gi] & ~g3t_reg[gi]);
    end
  endgenerate

  assign GPIO_IRQ = sfr_reg[SF_GIRQ] & (|gpio_hit);

  ////////////////////////////////////////////////////////////////////////
  // Read port.
  logic [15:0] bank_src;
  logic [7:0]  rd_mux;
  logic        hit;

  always_comb begin
    bank_src = gpio_rd;
    hit      = 1'b1;
    case (ADDR)
      ADR_GINT: bank_src = gint_reg;
      ADR_G3T:  bank_src = g3t_reg;
      ADR_GINV: bank_src = ginv_reg;
      ADR_GSEL: bank_src = gsel_reg;
      default:  bank_src = gpio_rd;
    endcase
    case (ADDR)
      ADR_MSR: rd_mux = {mdm_stat, delta_reg};
      ADR_SPR: begin
        if (gpio_map)
          rd_mux = sfr_reg[SF_BANK] ? bank_src[15:8]
                                    : bank_src[7:0];
        else if (swap)
          rd_mux = (enhanced_mode_ctrl_reg[0] && (!enhanced_mode_ctrl_reg[1] || alt_reg))
                   ? TX_LEVEL : RX_LEVEL;
        else
          rd_mux = scratch_reg;
      end
      ADR_GINT, ADR_G3T, ADR_GINV, ADR_GSEL: begin
        hit    = gpio_map;
        rd_mux = gpio_map ? (sfr_reg[SF_BANK] ? bank_src[15:8]
                                              : bank_src[7:0]) : ZERO8;
      end
      ADR_SHR, ADR_SFR: rd_mux = ZERO8;
      default: begin
        hit    = 1'b0;
        rd_mux = ZERO8;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_DATA <= ZERO8;
      RD_HIT  <= 1'b0;
    end else if (CE) begin
      RD_HIT <= RD & hit;
      if (RD)
        RD_DATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Half-duplex direction control, counted in bit ticks.
  umg_dir_state_type dir_state_reg;
  logic [4:0]        dir_cnt_reg;
  logic              cts_halt;
  logic              dir_tx;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dir_state_reg <= DIR_IDLE;
      dir_cnt_reg   <= 5'h00;
    end else if (CE) begin
      case (dir_state_reg)
        DIR_IDLE: begin
          if (rs485 && THR_WR) begin
            dir_cnt_reg <= {1'b0, shr_reg[7:4]};
            dir_state_reg <= (shr_reg[7:4] == 4'h0) ? DIR_SEND
                                                     : DIR_SETUP;
          end
        end
        DIR_SETUP: begin
          if (BIT_TICK) begin
            dir_cnt_reg <= dir_cnt_reg - 5'h01;
            if (dir_cnt_reg == 5'h01)
              dir_state_reg <= DIR_SEND;
          end
        end
        DIR_SEND: begin
          if (TX_EMPTY && !THR_WR) begin
            // One bit after the stop bit plus the programmed delay.
            dir_cnt_reg <= {1'b0, shr_reg[3:0]} + 5'h01;
            dir_state_reg <= DIR_HOLD;
          end
        end
        DIR_HOLD: begin
          if (THR_WR)
            dir_state_reg <= DIR_SEND;
          else if (BIT_TICK) begin
            dir_cnt_reg <= dir_cnt_reg - 5'h01;
            if (dir_cnt_reg == 5'h01)
              dir_state_reg <= DIR_IDLE;
          end
        end
        default: dir_state_reg <= DIR_IDLE;
      endcase
      if (!rs485)
        dir_state_reg <= DIR_IDLE;
    end
  end

  assign dir_tx   = dir_state_reg != DIR_IDLE;
  assign cts_halt = ENH_FEATURE[EF_ACTS] & ~mdm_stat[0];
  // The transmitter finishes its character before it samples this.
  assign TX_PERMIT = ~sfr_reg[SF_TXDIS] & ~cts_halt &
                     (~rs485 | dir_state_reg == DIR_SEND);

  always_ff @(posedge CLK) begin
    if (!RST_N)
      RTS_N <= 1'b1;
    else if (CE)
      RTS_N <= rs485 ? (dir_tx ~^ enhanced_mode_ctrl_reg[EM_RTSINV])
                     : ~MODEM_CTRL[MC_RTS];
  end

  logic err_seen_reg;

  assign LINE_IRQ = INT_ENABLE[IE_LINE] &
                    (enhanced_mode_ctrl_reg[EM_LSRIMM] ? err_seen_reg
                                         : RX_ERR_AT_HEAD);

  always_ff @(posedge CLK) begin
    if (!RST_N)
      err_seen_reg <= 1'b0;
    else if (CE)
      err_seen_reg <= (err_seen_reg & ~LSR_RD) | RX_ERR_ENQ;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_cts_change: assert property (CE && !loop && !rd_msr &&
    mdm_event[0] |=> delta_reg[0])
    else $error("cts change flag not set");
  a_ring_trail: assert property (CE && !rd_msr && !loop &&
    $fell(mdm_stat[2]) |=> delta_reg[2])
    else $error("ring trailing edge missed");
  a_ring_lead: assert property (CE && rd_msr && !loop &&
    $rose(mdm_stat[2]) |=> !delta_reg[2])
    else $error("ring leading edge flagged");
  a_loop_map: assert property (loop |-> mdm_stat ==
    {MODEM_CTRL[3], MODEM_CTRL[2], MODEM_CTRL[0], MODEM_CTRL[1]})
    else $error("loopback status mapping wrong");
  a_msr_clear: assert property (rd_msr && mdm_event == 4'h0
    |=> !MODEM_IRQ)
    else $error("modem interrupt after status read");
  a_scratch_rst: assert property ($rose(RST_N) |->
    scratch_reg == 8'hFF)
    else $error("scratch not all ones after reset");
  a_addr_clear: assert property (CE && THR_WR && !(wr_en &&
    ADDR == ADR_SFR) |=> !sfr_reg[7])
    else $error("address bit not cleared");
  a_bypass_clr: assert property (CE && TX_SENT && TX_BYPASS &&
    !wr_enhanced_mode_ctrl |=> !TX_BYPASS)
    else $error("immediate send not cleared");
  a_dir_level: assert property (rs485 && CE ##1 rs485 |->
    RTS_N == ($past(dir_tx) ~^ enhanced_mode_ctrl_reg[3]))
    else $error("direction level wrong");
  a_setup_len: assert property (CE && rs485 &&
    dir_state_reg == DIR_IDLE && THR_WR && shr_reg[7:4] == 4'h0
    |=> dir_state_reg == DIR_SEND)
    else $error("zero setup not immediate");
  a_pin_input: assert property (CE && !gsel_reg[0] |=>
    lvl_reg[0] == $past(lvl_reg[0]))
    else $error("input pin level written");

  c_msr_read: cover property (rd_msr && delta_reg != 4'h0);
  c_dir_cycle: cover property (dir_state_reg == DIR_HOLD
    ##[1:300] dir_state_reg == DIR_IDLE);
  c_alt_read: cover property (rd_count && alt_reg);
endmodule

// >>> umg_pkg.sv
/*
 * Constants for the serial port feature register block: local register
 * selects, field positions, reset values and the direction state type.
 * Assumes the host bus decoder outside turns bus cycles into a select code.
 */
package umg_pkg;
  localparam int ADDR_W = 4;
  localparam int GPIO_N = 16;
  // Local register select codes presented on ADDR.
  localparam logic [3:0] ADR_MSR  = 4'h6;
  localparam logic [3:0] ADR_SPR  = 4'h7;
  localparam logic [3:0] ADR_GINT = 4'h8;
  localparam logic [3:0] ADR_G3T  = 4'h9;
  localparam logic [3:0] ADR_GINV = 4'hA;
  localparam logic [3:0] ADR_GSEL = 4'hB;
  localparam logic [3:0] ADR_SHR  = 4'hC;
  localparam logic [3:0] ADR_SFR  = 4'hD;
  // Reset values.
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] ZERO8       = 8'h00;
  // Special function bits.
  localparam int SF_GPIO_EN = 0;
  localparam int SF_BANK    = 1;
  localparam int SF_GIRQ    = 2;
  localparam int SF_FASTIR  = 3;
  localparam int SF_TXDIS   = 4;
  localparam int SF_RXDIS   = 5;
  localparam int SF_NINE    = 6;
  localparam int SF_ADDRBIT = 7;
  localparam logic [7:0] SF_ALWAYS_MASK = 8'h07;
  // Enhanced mode bits.
  localparam int EM_IMM     = 2;
  localparam int EM_RTSINV  = 3;
  localparam int EM_TRI     = 4;
  localparam int EM_LSRIMM  = 6;
  localparam logic [7:0] EM_WR_MASK = 8'hDF;
  // Bits of neighbouring registers.
  localparam int FC_RS485   = 3;
  localparam int FC_SWAP    = 6;
  localparam int EF_ENH     = 4;
  localparam int EF_ACTS    = 7;
  localparam int IE_LINE    = 2;
  localparam int IE_MODEM   = 3;
  localparam int MC_DTR     = 0;
  localparam int MC_RTS     = 1;
  localparam int MC_OP1     = 2;
  localparam int MC_OP2     = 3;
  localparam int MC_LOOP    = 4;
  localparam logic [2:0] PAR_FORCE0 = 3'b111;
  // Infrared pulse widths in sixteenths of a bit time.
  localparam logic [2:0] IR_SLOW_16THS = 3'h3;
  localparam logic [2:0] IR_FAST_16THS = 3'h4;
  typedef enum logic [1:0] {
    DIR_IDLE, DIR_SETUP, DIR_SEND, DIR_HOLD
  } umg_dir_state_type;
endpackage

// >>> umg_host_model.sv
/*
 * Host side of the register port: one-cycle read and write strobes and a
 * bit-time tick for the direction timer.
 * Assumes the block takes a strobe on the rising edge of CLK.
 */
`timescale 1ns/100ps
module umg_host_model (
  // Clock
  input  wire logic       CLK,
  // Register port
  output logic      [3:0] ADDR,
  output logic            WR,
  output logic            RD,
  output logic      [7:0] WR_DATA,
  input  wire logic [7:0] RD_DATA,
  input  wire logic       RD_HIT,
  // Bit-time tick, one pulse every four cycles
  output logic            BIT_TICK
);
  logic [1:0] tick_reg = 2'h0;
  initial begin
    ADDR = 4'h0;
    WR = 1'b0;
    RD = 1'b0;
    WR_DATA = 8'h00;
    BIT_TICK = 1'b0;
  end
  always @(posedge CLK) begin
    tick_reg <= tick_reg + 2'h1;
    BIT_TICK <= (tick_reg == 2'h3);
  end
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    // Stale data would hide a decoder that ignores the strobe.
    WR_DATA <= ~v;
    #1;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v, output logic h);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    v = RD_DATA;
    h = RD_HIT;
  endtask
endmodule

// >>> umg_feature_regs_tb_top.sv
/*
 * Self-checking bench: a table of register accesses, then modem, pin,
 * direction, count and interrupt cases, and a second reset.
 * Assumes umg_host_model drives the register port and the bit tick.
 */
`timescale 1ns/100ps
module umg_feature_regs_tb_top;
  import umg_pkg::*;
  typedef struct {
    logic [3:0] a;
    logic       w;
    logic [7:0] wd, e;
    logic       h;
  } umg_row_type;
  logic CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, FIFO_EN = 1'b1;
  logic CTS_N = 1'b1, DSR_N = 1'b1, RI_N = 1'b1, CD_N = 1'b1;
  logic RX_ERR_AT_HEAD = 1'b0, TX_EMPTY = 1'b0;
  logic [3:0] p = 4'h0;
  wire  THR_WR, TX_SENT, RX_ERR_ENQ, LSR_RD;
  logic [3:0] ADDR;
  logic WR, RD, RD_HIT, BIT_TICK, RTS_N, MODEM_OE_N, TX_PERMIT, RX_ENABLE;
  logic TX_BYPASS, TX_NINTH, NINE_BIT_MODE, IR_FAST;
  logic MODEM_IRQ, GPIO_IRQ, LINE_IRQ;
  logic [2:0] IR_PULSE_16THS;
  logic [7:0] WR_DATA, RD_DATA, LINE_CTRL = 8'h00, MODEM_CTRL = 8'h00;
  logic [7:0] INT_ENABLE = 8'h0C, ENH_FEATURE = 8'h10, FEATURE_CTRL = 8'h00;
  logic [7:0] RX_LEVEL = 8'h05, TX_LEVEL = 8'h09, d;
  logic [15:0] GPIO_IN = 16'h00A0, GPIO_OUT, GPIO_OE_N;
  logic h;
  int bad_count = 0, comparisons = 0, n;
  umg_row_type rows [6] = '{
    '{ADR_SPR, 1'b0, 8'h00, 8'hFF, 1'b1}, '{ADR_MSR, 1'b0, 8'h00, 8'h00, 1'b1},
    '{ADR_GSEL, 1'b0, 8'h00, 8'h00, 1'b0}, '{4'h0, 1'b0, 8'h00, 8'h00, 1'b0},
    '{ADR_SPR, 1'b1, 8'hA5, 8'hA5, 1'b1}, '{ADR_SHR, 1'b1, 8'h21, 8'h00, 1'b1}};
  assign {LSR_RD, RX_ERR_ENQ, TX_SENT, THR_WR} = p;
  umg_feature_regs i_umg_feature_regs (.*);
  umg_host_model   i_umg_host_model (.*);
  initial forever #25 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rc(string s, logic [3:0] a, logic [7:0] e);
    i_umg_host_model.rd(a, d, h);
    chk(s, e, d);
  endtask
  task automatic w(logic [3:0] a, logic [7:0] v);
    i_umg_host_model.wr(a, v);
  endtask
  task automatic pulse(int k);
    @(posedge CLK);
    p[k] <= 1'b1;
    @(posedge CLK);
    p <= 4'h0;
    #1;
  endtask
  task automatic tmo;
    if (n >= 100) begin
      bad_count++;
      results;
    end
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) w(rows[i].a, rows[i].wd);
      rc("row data", rows[i].a, rows[i].e);
      chk("row hit", {7'h00, rows[i].h}, {7'h00, h});
    end
    $display("test table done");
    @(posedge CLK);
    CTS_N <= 1'b0;
    repeat (5) @(posedge CLK);
    #1;
    chk("modem irq", 8'h01, {7'h00, MODEM_IRQ});
    rc("status cts", ADR_MSR, 8'h11);
    rc("status clear", ADR_MSR, 8'h10);
    chk("modem irq off", 8'h00, {7'h00, MODEM_IRQ});
    RI_N <= 1'b0;
    repeat (5) @(posedge CLK);
    rc("ring on", ADR_MSR, 8'h50);
    RI_N <= 1'b1;
    repeat (5) @(posedge CLK);
    rc("ring end", ADR_MSR, 8'h14);
    MODEM_CTRL <= 8'h1F;
    repeat (4) @(posedge CLK);
    i_umg_host_model.rd(ADR_MSR, d, h);
    chk("loop status", 8'h0F, {4'h0, d[7:4]});
    MODEM_CTRL <= 8'h00;
    $display("test modem done");
    w(ADR_SFR, 8'h78);
    chk("sfr set", 8'h64, {1'b0, IR_FAST, IR_PULSE_16THS, NINE_BIT_MODE,
      TX_PERMIT, RX_ENABLE});
    ENH_FEATURE <= 8'h00;
    w(ADR_SFR, 8'h00);
    chk("sfr locked", 8'h64, {1'b0, IR_FAST, IR_PULSE_16THS, NINE_BIT_MODE,
      TX_PERMIT, RX_ENABLE});
    ENH_FEATURE <= 8'h10;
    LINE_CTRL <= 8'h38;
    w(ADR_SFR, 8'h80);
    chk("sfr clear", 8'h1B, {1'b0, IR_FAST, IR_PULSE_16THS, NINE_BIT_MODE,
      TX_PERMIT, RX_ENABLE});
    pulse(0);
    chk("ninth set", 8'h01, {7'h00, TX_NINTH});
    pulse(0);
    chk("ninth clear", 8'h00, {7'h00, TX_NINTH});
    $display("test special done");
    w(ADR_SFR, 8'h01);
    w(ADR_GSEL, 8'h0F);
    w(ADR_SPR, 8'hFF);
    rc("pin level", ADR_SPR, 8'hAF);
    chk("pin drive", 8'hF0, GPIO_OE_N[7:0]);
    chk("pin out", 8'h0F, GPIO_OUT[7:0]);
    w(ADR_SFR, 8'h07);
    rc("bank high", ADR_GSEL, 8'h00);
    w(ADR_GINT, 8'h01);
    chk("pin irq low", 8'h00, {7'h00, GPIO_IRQ});
    w(ADR_GINV, 8'h01);
    chk("pin irq inv", 8'h01, {7'h00, GPIO_IRQ});
    $display("test pins done");
    w(ADR_SFR, 8'h00);
    FEATURE_CTRL <= 8'h08;
    w(ADR_SHR, 8'h32);
    pulse(0);
    for (n = 0; n < 100 && TX_PERMIT !== 1'b1; n++) #50;
    tmo;
    chk("setup time", 8'h01, {7'h00, n >= 6});
    chk("dir tx", 8'h00, {7'h00, RTS_N});
    TX_EMPTY <= 1'b1;
    for (n = 0; n < 100 && RTS_N !== 1'b1; n++) #50;
    tmo;
    chk("hold time", 8'h01, {7'h00, n >= 6});
    TX_EMPTY <= 1'b0;
    FEATURE_CTRL <= 8'h40;
    $display("test direction done");
    w(ADR_SPR, 8'h13);
    chk("tristate", 8'h01, {7'h00, MODEM_OE_N});
    for (n = 0; n < 3; n++)
      rc("alt count", ADR_SPR, n[0] ? TX_LEVEL : RX_LEVEL);
    w(ADR_SPR, 8'h01);
    rc("tx count", ADR_SPR, TX_LEVEL);
    w(ADR_SPR, 8'h44);
    chk("bypass", 8'h01, {7'h00, TX_BYPASS});
    pulse(1);
    chk("bypass end", 8'h00, {7'h00, TX_BYPASS});
    pulse(2);
    chk("line irq", 8'h01, {7'h00, LINE_IRQ});
    pulse(3);
    chk("line irq off", 8'h00, {7'h00, LINE_IRQ});
    $display("test enhanced done");
    @(posedge CLK);
    RST_N <= 1'b0;
    FEATURE_CTRL <= 8'h00;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rc("scratch reset", ADR_SPR, 8'hFF);
    $display("test reset done");
    results;
  end
endmodule
